/* logic/itc_pkg.sv */
// Purpose: Shared constants and types for the three-counter interval timer.
// Assumes: Byte-wide I/O port access from a host engine on the same clock.
// Notes:   Counter tick rate is a parameter of the device end.
package itc_pkg;

  // ==========================================================================
  // Port map
  localparam logic [7:0] ITC_PORT_CNT0 = 8'h40;
  localparam logic [7:0] ITC_PORT_CNT1 = 8'h41;
  localparam logic [7:0] ITC_PORT_CNT2 = 8'h42;
  localparam logic [7:0] ITC_PORT_CMD  = 8'h43;

  // ==========================================================================
  // Command word fields
  localparam int ITC_SEL_HI   = 7;
  localparam int ITC_SEL_LO   = 6;
  localparam int ITC_RW_HI    = 5;
  localparam int ITC_RW_LO    = 4;
  localparam int ITC_MODE_HI  = 3;
  localparam int ITC_MODE_LO  = 1;
  localparam int ITC_BCD_BIT  = 0;
  localparam int ITC_RB_NCNT  = 5;
  localparam int ITC_RB_NSTAT = 4;
  localparam logic [1:0] ITC_SEL_READBACK = 2'h3;
  localparam logic [1:0] ITC_RW_LATCH     = 2'h0;
  localparam logic [1:0] ITC_RW_LSB       = 2'h1;
  localparam logic [1:0] ITC_RW_MSB       = 2'h2;
  localparam logic [1:0] ITC_RW_BOTH      = 2'h3;

  // ==========================================================================
  // Reset values and timing
  localparam logic [5:0]  ITC_CTRL_RST   = 6'h00;
  localparam logic [15:0] ITC_COUNT_RST  = 16'h0000;
  localparam real         ITC_CLK_MHZ    = 250.0;
  localparam real         ITC_REF_MHZ    = 14.31818;
  // Counter tick is the reference divided by twelve.
  localparam int          ITC_REF_DIV    = 12;
  localparam int          ITC_TICK_CYC   = int'(ITC_CLK_MHZ * ITC_REF_DIV / ITC_REF_MHZ);
  localparam int          ITC_NUM_CNT    = 3;

  typedef enum logic [1:0] {ITC_ACC_IDLE, ITC_ACC_WRITE, ITC_ACC_READ} itc_acc_t;

endpackage

/* logic/itc_if.sv */
// Purpose: Byte-wide I/O port link between the host engine and the timer.
// Assumes: Single clock; one access per strobe cycle.
// Notes:   Read data is returned one cycle after the read strobe.
`timescale 1ns/1ns
`default_nettype none
interface itc_if;
  logic       io_wr;
  logic       io_rd;
  logic [7:0] io_addr;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic       io_rvalid;

  modport dev (
    input  io_wr,
    input  io_rd,
    input  io_addr,
    input  io_wdata,
    output io_rdata,
    output io_rvalid
  );
  modport host (
    output io_wr,
    output io_rd,
    output io_addr,
    output io_wdata,
    input  io_rdata,
    input  io_rvalid
  );
endinterface
`default_nettype wire

/* logic/itc_counter.sv */
// Purpose: One 16-bit interval counter with mode, byte order and latches.
// Assumes: Strobes are single-cycle and already decoded for this counter.
// Notes:   BCD only changes decrement arithmetic.
`timescale 1ns/1ns
`default_nettype none
module itc_counter
  import itc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       tick,
  input  wire logic       gate,
  input  wire logic       ctrl_wr,
  input  wire logic [5:0] ctrl_val,
  input  wire logic       latch_cnt,
  input  wire logic       latch_stat,
  input  wire logic       data_wr,
  input  wire logic [7:0] data_in,
  input  wire logic       data_rd,
  // Results
  output logic [7:0]      data_out,
  output logic            out_pin
);

  logic [5:0]  ctrl_reg, ctrl_next;
  logic [15:0] count_reg, count_next;
  logic [15:0] init_reg, init_next;
  logic [15:0] olat_reg, olat_next;
  logic [7:0]  stat_reg, stat_next;
  logic        olat_v_reg, olat_v_next;
  logic        stat_v_reg, stat_v_next;
  logic        wr_hi_reg, wr_hi_next;
  logic        rd_hi_reg, rd_hi_next;
  logic        null_reg, null_next;
  logic        armed_reg, armed_next;
  logic        load_reg, load_next;
  logic        out_reg, out_next;
  logic        gate_q_reg;
  logic [7:0]  dout_reg, dout_next;

  logic [1:0]  rw;
  logic [2:0]  mode;
  logic [15:0] dec;

  // The stored control bits keep their command-word positions.
  assign rw       = ctrl_reg[ITC_RW_HI:ITC_RW_LO];
  assign mode     = ctrl_reg[ITC_MODE_HI:ITC_MODE_LO];
  assign data_out = dout_reg;
  assign out_pin  = out_reg;

  // Decrement by a step, in binary or four-digit BCD.
  function automatic logic [15:0] dec_by(input logic [15:0] v, input logic bcd, input logic [1:0] step);
    logic [15:0] r;
    logic [3:0]  d;
    logic [1:0]  b;
    r = v;
    b = step;
    if (!bcd) begin
      r = v - {14'h0000, step};
    end else begin
      for (int i = 0; i < 4; i++) begin
        d = r[i*4 +: 4];
        if (d >= {2'h0, b}) begin
          r[i*4 +: 4] = d - {2'h0, b};
          b = 2'h0;
        end else begin
          r[i*4 +: 4] = d + 4'hA - {2'h0, b};
          b = 2'h1;
        end
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // Next-state logic
  always_comb begin
    ctrl_next   = ctrl_reg;
    count_next  = count_reg;
    init_next   = init_reg;
    olat_next   = olat_reg;
    stat_next   = stat_reg;
    olat_v_next = olat_v_reg;
    stat_v_next = stat_v_reg;
    wr_hi_next  = wr_hi_reg;
    rd_hi_next  = rd_hi_reg;
    null_next   = null_reg;
    armed_next  = armed_reg;
    load_next   = 1'b0;
    out_next    = out_reg;
    dout_next   = dout_reg;
    dec         = 16'h0000;

    // Counting, advanced once per counter tick.
    // A pending load lands even with the gate low, so a stopped counter still shows its new count.
    if (tick && (gate || load_reg)) begin //R14
      if (load_reg || (mode == 3'h1 && gate && !gate_q_reg)) begin
        count_next = init_reg;
        null_next  = 1'b0;
        armed_next = 1'b1;
        if (mode == 3'h1) begin
          out_next = 1'b0;
        end
      end else begin
        dec = dec_by(count_reg, ctrl_reg[ITC_BCD_BIT], (mode[1:0] == 2'h3) ? 2'h2 : 2'h1);
        count_next = dec;
        case (mode)
          3'h0: begin
            if (dec == 16'h0000) out_next = 1'b1; //R7
          end
          3'h1: begin
            if (armed_reg && dec == 16'h0000) begin
              out_next   = 1'b1; //R8
              armed_next = 1'b0;
            end else if (!armed_reg && out_reg) begin
              out_next = 1'b0; //R8
            end
          end
          3'h2, 3'h6: begin
            if (!out_reg) begin
              out_next = 1'b1; //R9
            end else if (dec == 16'h0001) begin
              out_next = 1'b0;
            end else if (dec == 16'h0000) begin
              count_next = init_reg;
            end
            if (!out_reg) count_next = init_reg;
          end
          3'h3, 3'h7: begin
            if (dec == 16'h0000 || count_reg == 16'h0001) begin
              out_next   = ~out_reg; //R10
              count_next = init_reg;
            end
          end
          default: begin
            if (!out_reg) begin
              out_next = 1'b1; //R11
            end else if (armed_reg && dec == 16'h0000) begin
              out_next   = 1'b0;
              armed_next = 1'b0;
            end
          end
        endcase
      end
    end

    if (ctrl_wr) begin //R6
      ctrl_next   = ctrl_val;
      null_next   = 1'b1;
      wr_hi_next  = 1'b0;
      rd_hi_next  = 1'b0;
      olat_v_next = 1'b0;
      stat_v_next = 1'b0;
      armed_next  = 1'b0;
      out_next    = (ctrl_val[ITC_MODE_HI:ITC_MODE_LO] == 3'h0 ||
                     ctrl_val[ITC_MODE_HI:ITC_MODE_LO] == 3'h1) ? 1'b0 : 1'b1; //R7 R8 R9 R10 R11
    end else if (data_wr) begin //R3
      case (rw) //R2
        ITC_RW_LSB: begin
          init_next = {8'h00, data_in};
          load_next = 1'b1;
        end
        ITC_RW_MSB: begin
          init_next = {data_in, 8'h00};
          load_next = 1'b1;
        end
        ITC_RW_BOTH: begin
          if (!wr_hi_reg) begin
            init_next[7:0] = data_in; //R23
            wr_hi_next     = 1'b1;
          end else begin
            init_next[15:8] = data_in;
            wr_hi_next      = 1'b0;
            load_next       = 1'b1;
          end
        end
        default: begin
          init_next = init_reg;
        end
      endcase
      if (rw != ITC_RW_LATCH) null_next = 1'b1;
      if (mode == 3'h0 && load_next) out_next = 1'b0;
      if (mode[1:0] == 2'h0 && mode[2] == 1'b1 && load_next) armed_next = 1'b1;
    end

    if (latch_cnt && !olat_v_reg) begin //R15 R16 R19
      olat_next   = count_reg;
      olat_v_next = 1'b1;
    end
    if (latch_stat && !stat_v_reg) begin //R17 R19
      stat_next   = {out_reg, null_reg, ctrl_reg};
      stat_v_next = 1'b1;
    end

    if (data_rd) begin //R13 R20
      if (stat_v_reg) begin
        dout_next   = stat_reg;
        stat_v_next = 1'b0;
      end else begin
        case (rw)
          ITC_RW_MSB: begin
            dout_next   = olat_v_reg ? olat_reg[15:8] : count_reg[15:8];
            olat_v_next = 1'b0; //R18
          end
          ITC_RW_BOTH: begin
            if (!rd_hi_reg) begin
              dout_next  = olat_v_reg ? olat_reg[7:0] : count_reg[7:0]; //R23 R12
              rd_hi_next = 1'b1;
            end else begin
              dout_next   = olat_v_reg ? olat_reg[15:8] : count_reg[15:8];
              rd_hi_next  = 1'b0;
              olat_v_next = 1'b0;
            end
          end
          default: begin
            dout_next   = olat_v_reg ? olat_reg[7:0] : count_reg[7:0];
            olat_v_next = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg   <= ITC_CTRL_RST;
      count_reg  <= ITC_COUNT_RST;
      init_reg   <= ITC_COUNT_RST;
      olat_reg   <= ITC_COUNT_RST;
      stat_reg   <= 8'h00;
      olat_v_reg <= 1'b0;
      stat_v_reg <= 1'b0;
      wr_hi_reg  <= 1'b0;
      rd_hi_reg  <= 1'b0;
      null_reg   <= 1'b1;
      armed_reg  <= 1'b0;
      load_reg   <= 1'b0;
      out_reg    <= 1'b0;
      gate_q_reg <= 1'b0;
      dout_reg   <= 8'h00;
    end else begin
      ctrl_reg   <= ctrl_next;
      count_reg  <= count_next;
      init_reg   <= init_next;
      olat_reg   <= olat_next;
      stat_reg   <= stat_next;
      olat_v_reg <= olat_v_next;
      stat_v_reg <= stat_v_next;
      wr_hi_reg  <= wr_hi_next;
      rd_hi_reg  <= rd_hi_next;
      null_reg   <= null_next;
      armed_reg  <= armed_next;
      load_reg   <= load_next | (load_reg & ~tick);
      out_reg    <= out_next;
      gate_q_reg <= tick ? gate : gate_q_reg;
      dout_reg   <= dout_next;
    end
  end

endmodule
`default_nettype wire

/* logic/itc_device.sv */
// What this block does
// R1: Host writes control word before initial count.
// R2: Count bytes follow the programmed byte format.
// R3: New count keeps the programmed mode.
// R4: No interleaved writer within a two-byte load.
// R5: One command port decodes three command kinds.
// R6: Control word sets counter, mode, format, BCD.
// R7: Mode 0 output low, high at zero.
// R8: Mode 1 output low, one-tick high pulse.
// R9: Mode 2 idles high, one-tick low, reloads.
// R10: Mode 3 toggles each rollover, reloading count.
// R11: Modes 4 and 5 one-tick low strobe.
// R12: Other counters may be accessed between byte reads.
// R13: Ports 40h-42h read counters 0-2.
// R14: Counter 2 stops while its gate enable is low.
// R15: Latch command snapshots count, counting continues.
// R16: Second latch before read is ignored.
// R17: Read-back latches count and status together.
// R18: Each counter releases its latch when read.
// R19: Repeated latches without reads keep first values.
// R20: Status read first, then count bytes.
// R21: Counters tick from the reference clock rate.
// R22: Speaker output is zero during platform reset.
// R23: Separate write and read byte order, low first.
//
// Purpose: Device end: port decode and three interval counters.
// Assumes: Host keeps the write ordering for two-byte loads.
// Notes:   Counter 0 and 1 gates are held enabled.
`timescale 1ns/1ns
`default_nettype none
module itc_device
  import itc_pkg::*;
#(
  parameter int TICK_CYC = ITC_TICK_CYC
)(
  // Clock and reset
  input  wire logic clk,
  input  wire logic platform_reset_n,
  // Host port
  itc_if.dev        bus,
  // User side
  input  wire logic counter2_gate_enable,
  output logic      speaker_output,
  output logic [2:0] counter_out
);

  logic [15:0] tdiv_reg, tdiv_next;
  logic        tick;
  logic [2:0]  sel;
  logic [2:0]  ctrl_wr;
  logic [2:0]  latch_cnt;
  logic [2:0]  latch_stat;
  logic [2:0]  data_wr;
  logic [2:0]  data_rd;
  logic [2:0]  gate;
  logic [7:0]  dout [ITC_NUM_CNT];
  logic [2:0]  rd_sel_reg, rd_sel_next;
  logic        rvalid_reg, rvalid_next;
  logic        cmd_wr;
  logic [1:0]  csel;

  // ==========================================================================
  // Counter tick divider
  always_comb begin
    tdiv_next = (tdiv_reg == 16'(TICK_CYC - 1)) ? 16'h0000 : tdiv_reg + 16'h0001; //R21
  end
  assign tick = (tdiv_reg == 16'(TICK_CYC - 1));

  // ==========================================================================
  // Port decode
  assign cmd_wr = bus.io_wr && (bus.io_addr == ITC_PORT_CMD); //R5
  assign csel   = bus.io_wdata[ITC_SEL_HI:ITC_SEL_LO];
  assign gate   = {counter2_gate_enable, 2'b11}; //R14

  generate
    for (genvar i = 0; i < ITC_NUM_CNT; i++) begin : g_cnt
      logic is_rb;
      assign sel[i]        = (bus.io_addr == ITC_PORT_CNT0 + 8'(i)); //R13
      assign is_rb         = cmd_wr && (csel == ITC_SEL_READBACK) && bus.io_wdata[i+1];
      assign ctrl_wr[i]    = cmd_wr && (csel == 2'(i)) &&
                             (bus.io_wdata[ITC_RW_HI:ITC_RW_LO] != ITC_RW_LATCH); //R6
      assign latch_cnt[i]  = (cmd_wr && (csel == 2'(i)) &&
                              (bus.io_wdata[ITC_RW_HI:ITC_RW_LO] == ITC_RW_LATCH)) ||
                             (is_rb && !bus.io_wdata[ITC_RB_NCNT]); //R15 R17
      assign latch_stat[i] = is_rb && !bus.io_wdata[ITC_RB_NSTAT]; //R17
      assign data_wr[i]    = bus.io_wr && sel[i];
      assign data_rd[i]    = bus.io_rd && sel[i]; //R12 R18

      itc_counter u_cnt (
        .clk        (clk),
        .rst_n      (platform_reset_n),
        .tick       (tick),
        .gate       (gate[i]),
        .ctrl_wr    (ctrl_wr[i]),
        .ctrl_val   (bus.io_wdata[5:0]),
        .latch_cnt  (latch_cnt[i]),
        .latch_stat (latch_stat[i]),
        .data_wr    (data_wr[i]),
        .data_in    (bus.io_wdata),
        .data_rd    (data_rd[i]),
        .data_out   (dout[i]),
        .out_pin    (counter_out[i])
      );
    end
  endgenerate

  // ==========================================================================
  // Read return
  always_comb begin
    rd_sel_next = bus.io_rd ? sel : 3'b000;
    rvalid_next = bus.io_rd;
  end

  always_comb begin
    bus.io_rdata = 8'h00;
    for (int i = 0; i < ITC_NUM_CNT; i++) begin
      if (rd_sel_reg[i]) bus.io_rdata = dout[i];
    end
  end
  assign bus.io_rvalid = rvalid_reg;

  // Counter 2 output drives the speaker; reset forces it low.
  assign speaker_output = counter_out[2]; //R22

  always_ff @(posedge clk or negedge platform_reset_n) begin
    if (!platform_reset_n) begin
      tdiv_reg   <= 16'h0000;
      rd_sel_reg <= 3'b000;
      rvalid_reg <= 1'b0;
    end else begin
      tdiv_reg   <= tdiv_next;
      rd_sel_reg <= rd_sel_next;
      rvalid_reg <= rvalid_next;
    end
  end

endmodule
`default_nettype wire

/* logic/itc_host.sv */
// Purpose: Host end: turns user byte requests into I/O port strobes.
// Assumes: User issues one request at a time, waits for done.
// Notes:   Takes a new request only when idle; two-byte loads are not tracked.
`timescale 1ns/1ns
`default_nettype none
module itc_host
  import itc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Timer port
  itc_if.host             bus,
  // User request
  input  wire logic       req,
  input  wire logic       req_write,
  input  wire logic [1:0] req_port,
  input  wire logic [7:0] req_data,
  output logic            req_ready,
  // User answer
  output logic            done,
  output logic [7:0]      rsp_data
);

  itc_acc_t    st_reg, st_next;
  logic [7:0]  addr_reg, addr_next;
  logic [7:0]  wd_reg, wd_next;
  logic [7:0]  rsp_reg, rsp_next;
  logic        done_reg, done_next;

  always_comb begin
    st_next   = st_reg;
    addr_next = addr_reg;
    wd_next   = wd_reg;
    rsp_next  = rsp_reg;
    done_next = 1'b0;
    case (st_reg)
      ITC_ACC_IDLE: begin
        if (req) begin
          // Requests are served one at a time, in the order the user issues them. R1 R4
          addr_next = ITC_PORT_CNT0 + {6'h00, req_port};
          wd_next   = req_data;
          st_next   = req_write ? ITC_ACC_WRITE : ITC_ACC_READ;
        end
      end
      ITC_ACC_WRITE: begin
        done_next = 1'b1;
        st_next   = ITC_ACC_IDLE;
      end
      ITC_ACC_READ: begin
        if (bus.io_rvalid) begin
          rsp_next  = bus.io_rdata;
          done_next = 1'b1;
          st_next   = ITC_ACC_IDLE;
        end
      end
      default: st_next = ITC_ACC_IDLE;
    endcase
  end

  // Strobes last one cycle: the cycle after entering WRITE or READ.
  logic strobe_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg     <= ITC_ACC_IDLE;
      addr_reg   <= 8'h00;
      wd_reg     <= 8'h00;
      rsp_reg    <= 8'h00;
      done_reg   <= 1'b0;
      strobe_reg <= 1'b0;
    end else begin
      st_reg     <= st_next;
      addr_reg   <= addr_next;
      wd_reg     <= wd_next;
      rsp_reg    <= rsp_next;
      done_reg   <= done_next;
      strobe_reg <= (st_reg == ITC_ACC_IDLE) && req;
    end
  end

  assign bus.io_wr    = strobe_reg && (st_reg == ITC_ACC_WRITE); //R2
  assign bus.io_rd    = strobe_reg && (st_reg == ITC_ACC_READ); //R12
  assign bus.io_addr  = addr_reg;
  assign bus.io_wdata = wd_reg;
  assign req_ready    = (st_reg == ITC_ACC_IDLE);
  assign done         = done_reg;
  assign rsp_data     = rsp_reg;

endmodule
`default_nettype wire

/* tb/itc_link_assertions.sv */
// Purpose: Protocol checks on the byte link between host end and device end.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes:   Sees only the link, so count values are left to the bench.
`timescale 1ns/1ns
`default_nettype none
module itc_link_assertions (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Link
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_addr,
  input  wire logic [7:0] io_wdata,
  input  wire logic [7:0] io_rdata,
  input  wire logic       io_rvalid
);
  // ==========================================================================
  // Sequences
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence rd_strobe_s;
    io_rd ##1 !io_rd;
  endsequence
  sequence rd_answer_s;
    io_rvalid ##1 !io_rvalid;
  endsequence

  // ==========================================================================
  // Properties
  rd_answer_a: assert property (io_rd |-> ##1 rd_answer_s)
    else $error("read strobe not answered in the next cycle");
  rd_strobe_a: assert property ($rose(io_rd) |-> rd_strobe_s)
    else $error("read strobe longer than one cycle");
  rvalid_cause_a: assert property (io_rvalid |-> $past(io_rd))
    else $error("read answer without a read strobe");
  wr_pulse_a: assert property (io_wr |=> !io_wr)
    else $error("write strobe longer than one cycle");
  strobe_excl_a: assert property (!(io_wr && io_rd))
    else $error("read and write strobes together");
  port_range_a: assert property ((io_wr || io_rd) |-> io_addr[7:2] == 6'h10)
    else $error("strobe outside the four timer ports");
  answer_quiet_a: assert property (io_rvalid |-> !io_wr && !io_rd)
    else $error("new strobe during a read answer");
  strobe_gap_a: assert property (io_wr |=> (!io_wr && !io_rd) [*2])
    else $error("strobe too soon after a write");
  rdata_quiet_a: assert property (!io_rvalid |-> io_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
endmodule
`default_nettype wire

/* tb/interval_timer_three_counter_tb_top.sv */
// Purpose: Bench driving the host end against the device end.
// Assumes: Counter tick shortened to four clock cycles.
// Notes:   Counter 2 is gated off wherever an exact count is read back.
`timescale 1ns/1ns
`default_nettype none
`define ITC_CHK(nm, e, g) begin \
  checks_done++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); \
  end \
end
module interval_timer_three_counter_tb_top;
  import itc_pkg::*;
  localparam int TK = 4;
  logic        clk         = 1'b0;
  logic        rst_n       = 1'b0;
  logic        req         = 1'b0;
  logic        req_write   = 1'b0;
  logic [1:0]  req_port    = 2'h0;
  logic [7:0]  req_data    = 8'h00;
  logic        gate2       = 1'b0;
  logic        req_ready;
  logic        done;
  logic        spk;
  logic [7:0]  rsp_data;
  logic [2:0]  cout;
  logic [15:0] c;
  logic [7:0]  st;
  logic [7:0]  expq[3][$];
  int          errors      = 0;
  int          checks_done = 0;
  int          w;
  int          h;
  int          n;

  itc_if bus_if ();
  itc_device #(.TICK_CYC(TK)) itc_device_inst (.clk(clk), .platform_reset_n(rst_n), .bus(bus_if),
    .counter2_gate_enable(gate2), .speaker_output(spk), .counter_out(cout));
  itc_host itc_host_inst (.clk(clk), .rst_n(rst_n), .bus(bus_if), .req(req), .req_write(req_write),
    .req_port(req_port), .req_data(req_data), .req_ready(req_ready), .done(done), .rsp_data(rsp_data));
  itc_link_assertions itc_link_assertions_inst (.clk(clk), .rst_n(rst_n), .io_wr(bus_if.io_wr),
    .io_rd(bus_if.io_rd), .io_addr(bus_if.io_addr), .io_wdata(bus_if.io_wdata),
    .io_rdata(bus_if.io_rdata), .io_rvalid(bus_if.io_rvalid));

  always #2 clk = ~clk;

  // ==========================================================================
  // Tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic acc(input logic wr, input logic [1:0] p, input logic [7:0] d);
    int k;
    @(posedge clk);
    req       <= 1'b1;
    req_write <= wr;
    req_port  <= p;
    req_data  <= d;
    @(posedge clk);
    req <= 1'b0;
    for (k = 0; k < 20 && done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 20) begin
      errors++;
      end_sim();
    end
    `ITC_CHK("host ready after done", 1'b1, req_ready)
  endtask

  // Reads compare against the model queue only when it holds an expectation.
  task automatic rd(input logic [1:0] p);
    acc(1'b0, p, 8'h00);
    if (expq[p].size() > 0) begin
      st = expq[p].pop_front();
      `ITC_CHK("count port byte", st, rsp_data)
    end
  endtask

  task automatic tk(input int k);
    repeat (k * TK) @(posedge clk);
  endtask

  task automatic ld2();
    acc(1'b1, 2'd3, 8'hB0);
    acc(1'b1, 2'd2, c[7:0]);
    acc(1'b1, 2'd2, c[15:8]);
    tk(3);
  endtask

  task automatic push_lat();
    expq[2].push_back(8'h30);
    expq[2].push_back(c[7:0]);
    expq[2].push_back(c[15:8]);
  endtask

  task automatic meas(input logic idle);
    int k;
    for (k = 0; k < 200 && cout[2] === idle; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 200) begin
      errors++;
      end_sim();
    end
    for (w = 0; w < 200 && cout[2] !== idle; w++) begin
      @(posedge clk);
      #1;
    end
    for (h = 0; h < 200 && cout[2] === idle; h++) begin
      @(posedge clk);
      #1;
    end
  endtask

  // ==========================================================================
  // Sequence
  initial begin
    void'($urandom(94527));
    repeat (16) @(posedge clk);
    `ITC_CHK("speaker in reset", 1'b0, spk)
    rst_n <= 1'b1;
    c = 16'h8000 | 16'($urandom());
    ld2();
    expq[2].push_back(c[7:0]);
    expq[2].push_back(c[15:8]);
    rd(2'd2);
    acc(1'b1, 2'd3, 8'h50);
    rd(2'd2);
    for (int i = 1; i < 3; i++) begin
      acc(1'b1, 2'd3, {2'b10, i[1:0], 4'h0});
      repeat (2) begin
        st = 8'($urandom());
        acc(1'b1, 2'd2, st);
        tk(3);
        expq[2].push_back(st);
        rd(2'd2);
      end
    end
    $display("test byte formats done");
    c = 16'h8000 | 16'($urandom());
    ld2();
    acc(1'b1, 2'd3, 8'hC8);
    acc(1'b1, 2'd3, 8'hC8);
    push_lat();
    expq[2].push_back(c[7:0]);
    expq[2].push_back(c[15:8]);
    repeat (5) rd(2'd2);
    acc(1'b1, 2'd3, 8'h80);
    @(posedge clk);
    gate2 <= 1'b1;
    tk(4);
    gate2 <= 1'b0;
    acc(1'b1, 2'd3, 8'h80);
    acc(1'b1, 2'd3, 8'hE8);
    push_lat();
    repeat (3) rd(2'd2);
    $display("test latches done");
    for (int m = 0; m < 6; m++) begin
      @(posedge clk);
      gate2 <= 1'b0;
      n = 2 * int'($urandom_range(5, 2));
      acc(1'b1, 2'd3, {4'h9, m[2:0], 1'b0});
      acc(1'b1, 2'd2, n[7:0]);
      tk(2);
      gate2 <= 1'b1;
      meas(m > 1);
      `ITC_CHK("speaker level after measure", (m == 0 || m > 3) ? 1'b1 : 1'b0, spk)
      case (m)
        0: `ITC_CHK("mode 0 high time", 200, w)
        1: `ITC_CHK("mode 1 pulse", TK, w)
        2: begin
          `ITC_CHK("mode 2 pulse", TK, w)
          `ITC_CHK("mode 2 period", n * TK, w + h)
        end
        3: begin
          `ITC_CHK("mode 3 low half", n / 2 * TK, w)
          `ITC_CHK("mode 3 high half", n / 2 * TK, h)
        end
        default: `ITC_CHK("strobe width", TK, w)
      endcase
    end
    `ITC_CHK("counters 0 and 1 unloaded", 2'h0, cout[1:0])
    $display("test modes done");
    end_sim();
  end
endmodule
`default_nettype wire
